// File: rtl/cpu_arith_branch_ops.sv
// execution unit for the arithmetic and branch instruction group
// assumes an AXI4-Lite master on aclk; one machine cycle is one aclk cycle
//
// The AXI4-Lite interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/100ps
`include "ops_map.svh"

module cpu_arith_branch_ops (
  input wire logic aclk, // core clock, 200 MHz
  input wire logic aresetn, // synchronous reset, active low
  input wire logic [7:0] awaddr, // write address
  input wire logic awvalid, // write address valid
  output logic awready, // write address ready
  input wire logic [31:0] wdata, // write data
  input wire logic [3:0] wstrb, // write byte strobes
  input wire logic wvalid, // write data valid
  output logic wready, // write data ready
  output logic [1:0] bresp, // write response
  output logic bvalid, // write response valid
  input wire logic bready, // write response ready
  input wire logic [7:0] araddr, // read address
  input wire logic arvalid, // read address valid
  output logic arready, // read address ready
  output logic [31:0] rdata, // read data
  output logic [1:0] rresp, // read response
  output logic rvalid, // read data valid
  input wire logic rready // read data ready
);
  import ops_pkg::*;

  // =====================================================
  // helpers
  function automatic logic [31:0] apply_strb(input logic [31:0] old, input logic [31:0] upd,
                                              input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = upd[i*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic [15:0] branch_target(input logic [15:0] after, input logic [7:0] disp);
    return after + {{8{disp[7]}}, disp};
  endfunction

  function automatic decode_t decode(input logic [23:0] insn);
    decode_t d;
    logic [7:0] op;
    op = insn[7:0];
    d = '{kind: op_none, on_acc: 1'b0, len: `LEN_ONE, cycles: `CYC_ONE, disp: 8'h00};
    if (op == `OPC_DECADJ) begin
      d.kind = op_decadj;
      d.on_acc = 1'b1;
    end else if (op == `OPC_SUB1_A || op == `OPC_SUB1_DIR || op[7:3] == `PAT_SUB1_REG
                 || op[7:1] == `PAT_SUB1_IND) begin
      d.kind = op_sub1;
      d.on_acc = (op == `OPC_SUB1_A);
      d.len = (op == `OPC_SUB1_DIR) ? `LEN_TWO : `LEN_ONE;
    end else if (op == `OPC_ADD1_A || op == `OPC_ADD1_DIR || op[7:3] == `PAT_ADD1_REG
                 || op[7:1] == `PAT_ADD1_IND) begin
      d.kind = op_add1;
      d.on_acc = (op == `OPC_ADD1_A);
      d.len = (op == `OPC_ADD1_DIR) ? `LEN_TWO : `LEN_ONE;
    end else if (op == `OPC_QUOT) begin
      d.kind = op_quot;
      d.cycles = `CYC_QUOT;
    end else if (op[7:3] == `PAT_LOOP_REG) begin
      d.kind = op_loop;
      d.len = `LEN_TWO;
      d.cycles = `CYC_TWO;
      d.disp = insn[15:8];
    end else if (op == `OPC_LOOP_DIR) begin
      d.kind = op_loop;
      d.len = `LEN_THREE;
      d.cycles = `CYC_TWO;
      d.disp = insn[23:16];
    end else if (op == `OPC_PTR_ADD1) begin
      d.kind = op_ptr_add1;
      d.cycles = `CYC_TWO;
    end else if (op == `OPC_BSET || op == `OPC_BSETCLR || op == `OPC_BCLR) begin
      d.kind = (op == `OPC_BSET) ? op_bset : ((op == `OPC_BCLR) ? op_bclr : op_bsetclr);
      d.len = `LEN_THREE;
      d.cycles = `CYC_TWO;
      d.disp = insn[23:16];
    end else if (op == `OPC_BCY) begin
      d.kind = op_bcy;
      d.len = `LEN_TWO;
      d.cycles = `CYC_TWO;
      d.disp = insn[15:8];
    end else if (op == `OPC_IDXJUMP) begin
      d.kind = op_idxjump;
      d.cycles = `CYC_TWO;
    end
    return d;
  endfunction

  // =====================================================
  // state
  logic [7:0] acc_r;
  logic [7:0] aux_r;
  logic [7:0] flags_r;
  logic [15:0] ptr_r;
  logic [15:0] pc_r;
  logic [23:0] insn_r;
  logic [18:0] opnd_r;
  logic [11:0] result_r;
  logic illegal_r;
  logic [3:0] last_cycles_r;
  exec_state_t state_r;
  logic [3:0] cnt_r;
  logic aw_hold_r;
  logic w_hold_r;
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;

  logic wr_fire;
  logic wr_map;
  logic wr_ok;
  logic busy;
  logic go;
  logic retire;
  logic [31:0] insn_merge;
  decode_t dec_go;
  decode_t dec;
  logic [15:0] pc_after;
  logic [15:0] pc_new;
  logic [15:0] ptr_new;
  logic [7:0] acc_new;
  logic [7:0] aux_new;
  logic [7:0] flags_new;
  logic [7:0] src_byte;
  logic [7:0] new_byte;
  logic new_bit;
  logic test_bit;
  logic wr_byte;
  logic wr_bit;
  logic taken;
  logic [7:0] adj_byte;
  logic adj_cy;
  logic aw_hold_nxt;
  logic w_hold_nxt;
  logic bvalid_nxt;
  logic rvalid_nxt;

  div_if dv_bus ();

  ops_divider u_divider (
    .aclk(aclk),
    .aresetn(aresetn),
    .dv(dv_bus)
  );

  ops_decimal_adjust u_decadj (
    .acc_in(acc_r),
    .cy_in(flags_r[`FLAG_CY]),
    .hc_in(flags_r[`FLAG_HC]),
    .acc_out(adj_byte),
    .cy_out(adj_cy)
  );

  // =====================================================
  // write path decode
  assign busy = (state_r == st_run);
  assign wr_fire = aw_hold_r & w_hold_r & !bvalid;
  always_comb begin
    case (aw_addr_r)
      `ADDR_INSN, `ADDR_ACCAUX, `ADDR_FLAGS, `ADDR_PTR, `ADDR_PC, `ADDR_OPND: wr_map = 1'b1;
      default: wr_map = 1'b0;
    endcase
  end
  assign wr_ok = wr_fire & wr_map & !busy;
  assign insn_merge = apply_strb({8'h00, insn_r}, w_data_r, w_strb_r);
  assign go = wr_ok && (aw_addr_r == `ADDR_INSN) && insn_merge[`INSN_GO_BIT];
  assign dec_go = decode(insn_merge[23:0]);
  assign retire = busy && (cnt_r == 4'h0);

  assign dv_bus.start = go;
  assign dv_bus.dividend = acc_r;
  assign dv_bus.divisor = aux_r;

  // =====================================================
  // instruction semantics
  always_comb begin
    dec = decode(insn_r);
    pc_after = pc_r + {14'h0000, dec.len};
    src_byte = dec.on_acc ? acc_r
             : (opnd_r[`OPND_PORT] ? opnd_r[15:8] : opnd_r[7:0]);
    test_bit = opnd_r[`OPND_PINBIT];
    new_byte = src_byte;
    new_bit = 1'b0;
    wr_byte = 1'b0;
    wr_bit = 1'b0;
    taken = 1'b0;
    acc_new = acc_r;
    aux_new = aux_r;
    flags_new = flags_r;
    ptr_new = ptr_r;
    pc_new = pc_after;
    case (dec.kind)
      op_decadj: begin
        acc_new = adj_byte;
        flags_new[`FLAG_CY] = adj_cy;
      end
      op_sub1: begin
        new_byte = src_byte - 8'h01;
        wr_byte = !dec.on_acc;
        acc_new = dec.on_acc ? new_byte : acc_r;
      end
      op_add1: begin
        new_byte = src_byte + 8'h01;
        wr_byte = !dec.on_acc;
        acc_new = dec.on_acc ? new_byte : acc_r;
      end
      op_quot: begin
        acc_new = dv_bus.quotient;
        aux_new = dv_bus.remainder;
        flags_new[`FLAG_CY] = 1'b0;
        flags_new[`FLAG_SX] = (aux_r == 8'h00);
      end
      op_loop: begin
        new_byte = src_byte - 8'h01;
        wr_byte = 1'b1;
        taken = (new_byte != 8'h00);
      end
      op_ptr_add1: begin
        ptr_new = ptr_r + 16'h0001;
      end
      op_bset: begin
        taken = test_bit;
      end
      op_bsetclr: begin
        test_bit = opnd_r[`OPND_PORT] ? opnd_r[`OPND_LATBIT] : opnd_r[`OPND_PINBIT];
        taken = test_bit;
        wr_bit = 1'b1;
      end
      op_bclr: begin
        taken = !test_bit;
      end
      op_bcy: begin
        taken = flags_r[`FLAG_CY];
      end
      op_idxjump: begin
        pc_new = {8'h00, acc_r} + ptr_r;
      end
      default: begin
        pc_new = pc_r;
      end
    endcase
    if (taken) begin
      pc_new = branch_target(pc_after, dec.disp);
    end
  end

  // =====================================================
  // sequencing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= st_idle;
      cnt_r <= 4'h0;
    end else begin
      case (state_r)
        st_idle: begin
          if (go) begin
            state_r <= st_run;
            cnt_r <= dec_go.cycles - 4'h1;
          end
        end
        st_run: begin
          if (cnt_r == 4'h0) begin
            state_r <= st_idle;
          end else begin
            cnt_r <= cnt_r - 4'h1;
          end
        end
        default: begin
          state_r <= st_idle;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      illegal_r <= 1'b0;
      last_cycles_r <= 4'h0;
      result_r <= 12'h000;
    end else if (go) begin
      illegal_r <= (dec_go.kind == op_none);
    end else if (retire) begin
      last_cycles_r <= dec.cycles;
      result_r <= {taken, wr_bit, wr_byte, new_bit, new_byte};
    end
  end

  // =====================================================
  // architectural registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc_r <= `RST_BYTE;
      aux_r <= `RST_BYTE;
    end else if (retire) begin
      acc_r <= acc_new;
      aux_r <= aux_new;
    end else if (wr_ok && aw_addr_r == `ADDR_ACCAUX) begin
      {aux_r, acc_r} <= 16'(apply_strb({16'h0000, aux_r, acc_r}, w_data_r, w_strb_r));
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_r <= `RST_BYTE;
    end else if (retire) begin
      flags_r <= flags_new;
    end else if (wr_ok && aw_addr_r == `ADDR_FLAGS) begin
      flags_r <= 8'(apply_strb({24'h000000, flags_r}, w_data_r, w_strb_r));
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ptr_r <= `RST_WORD;
      pc_r <= `RST_WORD;
    end else if (retire) begin
      ptr_r <= ptr_new;
      pc_r <= pc_new;
    end else if (wr_ok && aw_addr_r == `ADDR_PTR) begin
      ptr_r <= 16'(apply_strb({16'h0000, ptr_r}, w_data_r, w_strb_r));
    end else if (wr_ok && aw_addr_r == `ADDR_PC) begin
      pc_r <= 16'(apply_strb({16'h0000, pc_r}, w_data_r, w_strb_r));
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      insn_r <= 24'h000000;
      opnd_r <= 19'h00000;
    end else if (wr_ok && aw_addr_r == `ADDR_INSN) begin
      insn_r <= insn_merge[23:0];
    end else if (wr_ok && aw_addr_r == `ADDR_OPND) begin
      opnd_r <= 19'(apply_strb({13'h0000, opnd_r}, w_data_r, w_strb_r));
    end
  end

  // =====================================================
  // axi4-lite write channel
  assign aw_hold_nxt = !wr_fire & (aw_hold_r | (awvalid & awready));
  assign w_hold_nxt = !wr_fire & (w_hold_r | (wvalid & wready));
  assign bvalid_nxt = wr_fire | (bvalid & !bready);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h00000000;
      w_strb_r <= 4'h0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
    end else begin
      aw_hold_r <= aw_hold_nxt;
      w_hold_r <= w_hold_nxt;
      if (awvalid && awready) begin
        aw_addr_r <= {awaddr[7:2], 2'h0};
      end
      if (wvalid && wready) begin
        w_data_r <= wdata;
        w_strb_r <= wstrb;
      end
      awready <= !aw_hold_nxt & !bvalid_nxt;
      wready <= !w_hold_nxt & !bvalid_nxt;
      bvalid <= bvalid_nxt;
      if (wr_fire) begin
        bresp <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
      end
    end
  end

  // =====================================================
  // axi4-lite read channel
  assign rvalid_nxt = (arvalid & arready) | (rvalid & !rready);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= `RESP_OKAY;
    end else begin
      arready <= !rvalid_nxt;
      rvalid <= rvalid_nxt;
      if (arvalid && arready) begin
        rresp <= `RESP_OKAY;
        case ({araddr[7:2], 2'h0})
          `ADDR_INSN: rdata <= {8'h00, insn_r};
          `ADDR_ACCAUX: rdata <= {16'h0000, aux_r, acc_r};
          `ADDR_FLAGS: rdata <= {24'h000000, flags_r};
          `ADDR_PTR: rdata <= {16'h0000, ptr_r};
          `ADDR_PC: rdata <= {16'h0000, pc_r};
          `ADDR_OPND: rdata <= {13'h0000, opnd_r};
          `ADDR_RESULT: rdata <= {20'h00000, result_r};
          `ADDR_STATUS: rdata <= {16'h0000, 4'h0, last_cycles_r, 6'h00, illegal_r, busy};
          default: begin
            rdata <= 32'h00000000;
            rresp <= `RESP_SLVERR;
          end
        endcase
      end
    end
  end
endmodule

// File: rtl/ops_map.svh
// offsets, field positions, opcodes, reset values and cycle counts
// assumes inclusion by the execution unit, divider and decimal adjust files of the arithmetic/branch unit
`ifndef OPS_MAP_SVH
`define OPS_MAP_SVH
`define ADDR_INSN 8'h00
`define ADDR_ACCAUX 8'h04
`define ADDR_FLAGS 8'h08
`define ADDR_PTR 8'h0c
`define ADDR_PC 8'h10
`define ADDR_OPND 8'h14
`define ADDR_RESULT 8'h18
`define ADDR_STATUS 8'h1c
`define INSN_GO_BIT 31
`define FLAG_CY 7
`define FLAG_HC 6
`define FLAG_SX 2
`define OPND_PORT 16
`define OPND_PINBIT 17
`define OPND_LATBIT 18
`define OPC_DECADJ 8'hd4
`define OPC_SUB1_A 8'h14
`define OPC_SUB1_DIR 8'h15
`define PAT_SUB1_REG 5'h03
`define PAT_SUB1_IND 7'h0b
`define OPC_ADD1_A 8'h04
`define OPC_ADD1_DIR 8'h05
`define PAT_ADD1_REG 5'h01
`define PAT_ADD1_IND 7'h03
`define OPC_QUOT 8'h84
`define PAT_LOOP_REG 5'h1b
`define OPC_LOOP_DIR 8'hd5
`define OPC_PTR_ADD1 8'ha3
`define OPC_BSET 8'h20
`define OPC_BSETCLR 8'h10
`define OPC_BCLR 8'h30
`define OPC_BCY 8'h40
`define OPC_IDXJUMP 8'h73
`define BCD_LIMIT 4'h9
`define BCD_FIX 4'h6
`define LEN_ONE 2'h1
`define LEN_TWO 2'h2
`define LEN_THREE 2'h3
`define CYC_ONE 4'h1
`define CYC_TWO 4'h2
`define CYC_QUOT 4'h4
`define DIV_STEPS 2'h2
`define RST_BYTE 8'h00
`define RST_WORD 16'h0000
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// File: rtl/ops_pkg.sv
// types shared by the execution unit and its helpers
// assumes nothing beyond the compile order
package ops_pkg;
  typedef enum logic [3:0] {
    op_none = 4'b0000,
    op_decadj = 4'b0001,
    op_sub1 = 4'b0010,
    op_add1 = 4'b0011,
    op_quot = 4'b0100,
    op_loop = 4'b0101,
    op_ptr_add1 = 4'b0110,
    op_bset = 4'b0111,
    op_bsetclr = 4'b1000,
    op_bclr = 4'b1001,
    op_bcy = 4'b1010,
    op_idxjump = 4'b1011
  } op_kind_t;
  typedef enum logic {
    st_idle = 1'b0,
    st_run = 1'b1
  } exec_state_t;
  typedef struct packed {
    op_kind_t kind;
    logic on_acc;
    logic [1:0] len;
    logic [3:0] cycles;
    logic [7:0] disp;
  } decode_t;
endpackage

// File: rtl/div_if.sv
// operand and result bundle between execution unit and divider
// assumes both ends on aclk
`timescale 1ns/100ps
interface div_if;
  logic start;
  logic [7:0] dividend;
  logic [7:0] divisor;
  logic [7:0] quotient;
  logic [7:0] remainder;
  logic done;
  modport owner (output start, dividend, divisor, input quotient, remainder, done);
  modport unit (input start, dividend, divisor, output quotient, remainder, done);
endinterface

// File: rtl/ops_divider.sv
// unsigned 8 by 8 restoring divider, four bits per clock
// assumes operands stable only at the start edge
`timescale 1ns/100ps
`include "ops_map.svh"

module ops_divider (
  input wire logic aclk, // core clock
  input wire logic aresetn, // synchronous reset, active low
  div_if.unit dv // operands in, results out
);
  import ops_pkg::*;

  logic [7:0] quo_r;
  logic [7:0] rem_r;
  logic [7:0] den_r;
  logic [1:0] step_r;

  function automatic logic [15:0] four_steps(input logic [7:0] rem, input logic [7:0] quo,
                                              input logic [7:0] den);
    logic [8:0] trial;
    logic [7:0] r;
    logic [7:0] q;
    r = rem;
    q = quo;
    for (int i = 0; i < 4; i++) begin
      trial = {r, q[7]} - {1'b0, den};
      if (!trial[8]) begin
        r = trial[7:0];
      end else begin
        r = {r[6:0], q[7]};
      end
      q = {q[6:0], !trial[8]};
    end
    return {r, q};
  endfunction

  // =====================================================
  // iteration
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      quo_r <= `RST_BYTE;
      rem_r <= `RST_BYTE;
      den_r <= `RST_BYTE;
      step_r <= 2'h0;
    end else if (dv.start) begin
      quo_r <= dv.dividend;
      rem_r <= `RST_BYTE;
      den_r <= dv.divisor;
      step_r <= `DIV_STEPS;
    end else if (step_r != 2'h0) begin
      {rem_r, quo_r} <= four_steps(rem_r, quo_r, den_r);
      step_r <= step_r - 2'h1;
    end
  end

  assign dv.quotient = quo_r;
  assign dv.remainder = rem_r;
  assign dv.done = (step_r == 2'h0);
endmodule

// File: rtl/ops_decimal_adjust.sv
// packed bcd correction of the accumulator after an addition
// assumes carry and half carry as left by the preceding addition
`timescale 1ns/100ps
`include "ops_map.svh"

module ops_decimal_adjust (
  input wire logic [7:0] acc_in, // accumulator before correction
  input wire logic cy_in, // carry flag
  input wire logic hc_in, // half carry flag
  output logic [7:0] acc_out, // corrected accumulator
  output logic cy_out // carry after correction
);
  logic [8:0] low_fix;
  logic [8:0] high_fix;
  logic cy_mid;

  always_comb begin
    low_fix = {1'b0, acc_in};
    if (acc_in[3:0] > `BCD_LIMIT || hc_in) begin
      low_fix = {1'b0, acc_in} + {5'h00, `BCD_FIX};
    end
    cy_mid = cy_in | low_fix[8];
    high_fix = {1'b0, low_fix[7:0]};
    if (low_fix[7:4] > `BCD_LIMIT || cy_mid) begin
      high_fix = {1'b0, low_fix[7:0]} + {1'b0, `BCD_FIX, 4'h0};
    end
    acc_out = high_fix[7:0];
    cy_out = cy_mid | high_fix[8];
  end
endmodule

// File: tb/cpu_arith_branch_ops_monitor.sv
// bus handshake assertions for the execution unit
// assumes one aclk domain with a synchronous active-low reset
`timescale 1ns/100ps
module cpu_arith_branch_ops_monitor (
  input wire logic aclk, // clock
  input wire logic aresetn, // reset
  input wire logic awvalid, // aw valid
  input wire logic awready, // aw ready
  input wire logic wvalid, // w valid
  input wire logic wready, // w ready
  input wire logic [1:0] bresp, // b resp
  input wire logic bvalid, // b valid
  input wire logic bready, // b ready
  input wire logic arvalid, // ar valid
  input wire logic arready, // ar ready
  input wire logic [31:0] rdata, // r data
  input wire logic [1:0] rresp, // r resp
  input wire logic rvalid, // r valid
  input wire logic rready // r ready
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_b_hold;
    bvalid && !bready |=> bvalid && $stable(bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
  property p_r_hold;
    rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data changed while waiting");
  property p_b_lat;
    awvalid && awready && wvalid && wready |=> !bvalid ##1 bvalid;
  endproperty
  a_b_lat: assert property (p_b_lat) else $error("write response latency wrong");
  property p_r_lat;
    arvalid && arready |=> rvalid;
  endproperty
  a_r_lat: assert property (p_r_lat) else $error("read data latency wrong");
  property p_ar_block;
    rvalid |-> !arready;
  endproperty
  a_ar_block: assert property (p_ar_block) else $error("read address taken while busy");
  property p_r_done;
    rvalid && rready |=> !rvalid && arready;
  endproperty
  a_r_done: assert property (p_r_done) else $error("read channel not released");
  property p_b_done;
    bvalid && bready |=> !bvalid && awready && wready;
  endproperty
  a_b_done: assert property (p_b_done) else $error("write channel not released");
  property p_rst;
    $rose(aresetn) |-> !awready && !arready ##1 awready && arready;
  endproperty
  a_rst: assert property (p_rst) else $error("ready after reset wrong");
endmodule

bind cpu_arith_branch_ops cpu_arith_branch_ops_monitor i_mon (
  .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
  .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
  .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
  .rvalid(rvalid), .rready(rready)
);

// File: tb/test_cpu_arith_branch_ops.sv
// self-checking bench driving the execution unit over its register bus
// assumes the unit's register map and busy flag in STATUS
`timescale 1ns/100ps
`include "ops_map.svh"
module test_cpu_arith_branch_ops;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic [7:0] araddr = 8'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, d;
  int failures = 0;
  int n_tests = 0;
  int tn = 0;
  always #2.5 aclk = ~aclk;
  cpu_arith_branch_ops i_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready));
  // ==========
  // bus tasks
  task automatic chk(input logic [31:0] g, input logic [31:0] v, input logic [31:0] m);
    n_tests++;
    if ((g & m) !== (v & m)) begin
      failures++;
      $display("BAD %0t test %0d got %h want %h", $time, tn, g, v);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    awaddr <= a;
    wdata <= v;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge aclk);
      if (!ad && awready) begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (!wd && wready) begin
        wd = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!bvalid);
    r = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask
  // ==========
  // instruction run and result check
  task automatic x(input logic [23:0] op, input logic [15:0] aa, input logic [7:0] fl,
      input logic [15:0] dp, input logic [18:0] od);
    tn++;
    wr(`ADDR_PC, 32'h100, 4'hf);
    wr(`ADDR_ACCAUX, {16'h0, aa}, 4'hf);
    wr(`ADDR_FLAGS, {24'h0, fl}, 4'hf);
    wr(`ADDR_PTR, {16'h0, dp}, 4'hf);
    wr(`ADDR_OPND, {13'h0, od}, 4'hf);
    wr(`ADDR_INSN, {8'h80, op}, 4'hf);
    chk({30'h0, r}, {30'h0, `RESP_OKAY}, 32'h3);
    d = 32'h1;
    while (d[0] !== 1'b0) rd(`ADDR_STATUS);
  endtask
  task automatic e(input logic [15:0] aa, input logic [15:0] ma, input logic [7:0] fl,
      input logic [15:0] dp, input logic [15:0] pc, input logic [11:0] res,
      input logic [11:0] mr, input logic [3:0] cy);
    chk(d, {20'h0, cy, 8'h0}, 32'hf03);
    rd(`ADDR_ACCAUX);
    chk(d, {16'h0, aa}, {16'hffff, ma});
    rd(`ADDR_FLAGS);
    chk(d, {24'h0, fl}, 32'hffffffff);
    rd(`ADDR_PTR);
    chk(d, {16'h0, dp}, 32'hffffffff);
    rd(`ADDR_PC);
    chk(d, {16'h0, pc}, 32'hffffffff);
    rd(`ADDR_RESULT);
    chk(d, {20'h0, res}, {20'h0, mr});
    $display("test %0d done", tn);
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // ==========
  // watchdog
  initial begin
    repeat (20000) @(posedge aclk);
    failures++;
    $display("BAD %0t watchdog expired", $time);
    final_report;
  end
  // ==========
  // tests
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    tn++;
    rd(`ADDR_PC);
    chk(d, 32'h0, 32'hffffffff);
    rd(8'h24);
    chk({30'h0, r}, {30'h0, `RESP_SLVERR}, 32'h3);
    wr(`ADDR_RESULT, 32'hfff, 4'hf);
    chk({30'h0, r}, {30'h0, `RESP_SLVERR}, 32'h3);
    wr(`ADDR_ACCAUX, 32'h1122, 4'hf);
    wr(`ADDR_ACCAUX, 32'h33ff, 4'h1);
    rd(`ADDR_ACCAUX);
    chk(d, 32'h11ff, 32'hffffffff);
    $display("test %0d done", tn);
    x(24'hd4, 16'hbe, 8'h0, 16'h0, 19'h0);
    e(16'h24, 16'hffff, 8'h80, 16'h0, 16'h101, 12'h0, 12'he00, 4'h1);
    x(24'hd4, 16'h30, 8'h84, 16'h0, 19'h0);
    e(16'h90, 16'hffff, 8'h84, 16'h0, 16'h101, 12'h0, 12'he00, 4'h1);
    x(24'h14, 16'h5500, 8'hc4, 16'h0, 19'h0);
    e(16'h55ff, 16'hffff, 8'hc4, 16'h0, 16'h101, 12'h0, 12'he00, 4'h1);
    x(24'h1d, 16'h1234, 8'hc4, 16'h0, 19'h0);
    e(16'h1234, 16'hffff, 8'hc4, 16'h0, 16'h101, 12'h2ff, 12'hfff, 4'h1);
    x(24'h3015, 16'h0, 8'h0, 16'h0, 19'h1407f);
    e(16'h0, 16'hffff, 8'h0, 16'h0, 16'h102, 12'h23f, 12'hfff, 4'h1);
    x(24'h04, 16'hff, 8'hc4, 16'h0, 19'h0);
    e(16'h0, 16'hffff, 8'hc4, 16'h0, 16'h101, 12'h0, 12'he00, 4'h1);
    x(24'ha5, 16'h0, 8'h0, 16'h0, 19'h0);
    chk(d, 32'h102, 32'hf03);
    rd(`ADDR_PC);
    chk(d, 32'h100, 32'hffffffff);
    $display("test %0d done", tn);
    x(24'h07, 16'h0, 8'hc4, 16'h0, 19'hff);
    e(16'h0, 16'hffff, 8'hc4, 16'h0, 16'h101, 12'h200, 12'hfff, 4'h1);
    x(24'h4005, 16'h0, 8'h0, 16'h0, 19'h1127f);
    e(16'h0, 16'hffff, 8'h0, 16'h0, 16'h102, 12'h213, 12'hfff, 4'h1);
    x(24'h0b, 16'h0, 8'h0, 16'h0, 19'h7f);
    e(16'h0, 16'hffff, 8'h0, 16'h0, 16'h101, 12'h280, 12'hfff, 4'h1);
    x(24'h16, 16'h0, 8'h0, 16'h0, 19'h0);
    e(16'h0, 16'hffff, 8'h0, 16'h0, 16'h101, 12'h2ff, 12'hfff, 4'h1);
    x(24'hd4, 16'h31, 8'h40, 16'h0, 19'h0);
    e(16'h37, 16'hffff, 8'h40, 16'h0, 16'h101, 12'h0, 12'he00, 4'h1);
    x(24'h058810, 16'h0, 8'h0, 16'h0, 19'h30000);
    e(16'h0, 16'hffff, 8'h0, 16'h0, 16'h103, 12'h400, 12'hf00, 4'h2);
    tn++;
    wr(`ADDR_ACCAUX, 32'h0203, 4'hf);
    wr(`ADDR_INSN, 32'h80000084, 4'hf);
    wr(`ADDR_ACCAUX, 32'h5555, 4'hf);
    chk({30'h0, r}, {30'h0, `RESP_SLVERR}, 32'h3);
    d = 32'h1;
    while (d[0] !== 1'b0) rd(`ADDR_STATUS);
    rd(`ADDR_ACCAUX);
    chk(d, 32'h0101, 32'hffffffff);
    $display("test %0d done", tn);
    x(24'h84, 16'h12fb, 8'h84, 16'h0, 19'h0);
    e(16'h110d, 16'hffff, 8'h0, 16'h0, 16'h101, 12'h0, 12'he00, 4'h4);
    x(24'h84, 16'h40, 8'h80, 16'h0, 19'h0);
    e(16'h0, 16'h0, 8'h04, 16'h0, 16'h101, 12'h0, 12'he00, 4'h4);
    x(24'hfedd, 16'h0, 8'h0, 16'h0, 19'h01);
    e(16'h0, 16'hffff, 8'h0, 16'h0, 16'h102, 12'h200, 12'hfff, 4'h2);
    x(24'hfcdc, 16'h0, 8'h0, 16'h0, 19'h0);
    e(16'h0, 16'hffff, 8'h0, 16'h0, 16'hfe, 12'haff, 12'hfff, 4'h2);
    x(24'h1090d5, 16'h0, 8'h0, 16'h0, 19'h10501);
    e(16'h0, 16'hffff, 8'h0, 16'h0, 16'h113, 12'ha04, 12'hfff, 4'h2);
    x(24'ha3, 16'h0, 8'hc4, 16'hffff, 19'h0);
    e(16'h0, 16'hffff, 8'hc4, 16'h0, 16'h101, 12'h0, 12'he00, 4'h2);
    x(24'h808820, 16'h0, 8'hc4, 16'h0, 19'h20000);
    e(16'h0, 16'hffff, 8'hc4, 16'h0, 16'h83, 12'h800, 12'hf00, 4'h2);
    x(24'h808820, 16'h0, 8'h0, 16'h0, 19'h50000);
    e(16'h0, 16'hffff, 8'h0, 16'h0, 16'h103, 12'h0, 12'hf00, 4'h2);
    x(24'h058810, 16'h0, 8'h0, 16'h0, 19'h50000);
    e(16'h0, 16'hffff, 8'h0, 16'h0, 16'h108, 12'hc00, 12'hf00, 4'h2);
    x(24'h058830, 16'h0, 8'h0, 16'h0, 19'h0);
    e(16'h0, 16'hffff, 8'h0, 16'h0, 16'h108, 12'h800, 12'hf00, 4'h2);
    x(24'h7f40, 16'h0, 8'h80, 16'h0, 19'h0);
    e(16'h0, 16'hffff, 8'h80, 16'h0, 16'h181, 12'h800, 12'hf00, 4'h2);
    x(24'h7f40, 16'h0, 8'h44, 16'h0, 19'h0);
    e(16'h0, 16'hffff, 8'h44, 16'h0, 16'h102, 12'h0, 12'hf00, 4'h2);
    x(24'h73, 16'hf0, 8'h0, 16'hff20, 19'h0);
    e(16'hf0, 16'hffff, 8'h0, 16'hff20, 16'h10, 12'h0, 12'h800, 4'h2);
    final_report;
  end
endmodule
